// File: logic/radio_mode_cfg.svh
`ifndef RADIO_MODE_CFG_SVH
`define RADIO_MODE_CFG_SVH

// Register byte offsets
`define RMB_OFF_OWN_ADDR 12'h000
`define RMB_OFF_SUBPKT 12'h004
`define RMB_OFF_STATUS 12'h008

// Reset values
`define RMB_RST_OWN_ADDR 16'h0001
`define RMB_RST_SUBPKT 8'hf0

// Broadcast and monitor addresses
`define RMB_ADDR_ALL_HI 16'hffff
`define RMB_ADDR_ALL_LO 16'h0000

// Status field positions
`define RMB_ST_READY 0
`define RMB_ST_WORKING 1
`define RMB_ST_MODE_LSB 2
`define RMB_ST_STATE_LSB 4
`define RMB_ST_LEVEL_LSB 8

// Timing
`define RMB_CLK_KHZ 40000
`define RMB_SETTLE_TIME_US 2000
`define RMB_SELFCHECK_TIME_US 500
`define RMB_RELOAD_TIME_US 200

`endif

// File: logic/radio_mode_pkg.sv
package radio_mode_pkg;

  typedef enum logic [1:0] {
    ST_CHECK = 2'b00,
    ST_RELOAD = 2'b01,
    ST_RUN = 2'b11
  } busy_state_t;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_WOR = 2'b01,
    MODE_CONFIG = 2'b10,
    MODE_SLEEP = 2'b11
  } op_mode_t;

endpackage

// File: logic/byte_fifo.sv
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 1000,
  parameter int LW = $clog2(DEPTH + 1)
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [LW-1:0] level
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [LW-1:0] level_ff;

  wire push = in_valid & in_ready & clk_en;
  wire pop = out_valid & out_ready & clk_en;
  wire [PW-1:0] wr_next = (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
  wire [PW-1:0] rd_next = (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;

  assign in_ready = (level_ff != LW'(DEPTH));
  assign out_valid = (level_ff != '0);
  assign out_data = mem[rd_ptr_ff];
  assign level = level_ff;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      level_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_next;
      if (pop) rd_ptr_ff <= rd_next;
      if (push && !pop) level_ff <= level_ff + 1'b1;
      else if (pop && !push) level_ff <= level_ff - 1'b1;
    end
  end

endmodule

// File: logic/radio_mode_busy.sv
`include "radio_mode_cfg.svh"

// Function
// - Decode both mode-select inputs together into one of four modes.
// - At power-up hold ready low through self-check and reload, then raise it.
// - Ready stays low for the whole self-check.
// - Self-check runs only at power-on reset; leaving sleep goes straight to reload.
// - 1000-byte buffer drains to the radio, split into sub-packets.
// - While ready is high a burst under 1000 bytes never overflows.
// - Ready stays low while buffered data has not all gone to the radio.
// - Ready is low if any busy condition holds, high only when none does.
// - Mode inputs are not evaluated while ready is low, except to pick the mode at the end of reload.
// - A pending mode switch completes within 1 ms after ready rises.
// - New mode works only once ready has been high 2 ms.
// - Pins changing while ready stays high switch the mode at once.
// - Leaving sleep or resetting reloads parameters with ready low.
// - Ready shows status and goes low before UART output to wake host; here it falls the cycle after uart_out_active rises.
// - All-ones or all-zero own address makes transmissions reach everyone.
// - All-ones or all-zero own address accepts packets from every sender.
// - Serial data comes in from the host and goes out to the radio.
// - Encoding high/low: 00 normal, 01 wake-on-radio, 10 config, 11 sleep.
// - Mode switch waits while data is pending for air or UART output.
module radio_mode_busy #(
  parameter int BUF_DEPTH = 1000,
  parameter int SETTLE_CYC = `RMB_SETTLE_TIME_US * (`RMB_CLK_KHZ / 1000),
  parameter int CHECK_CYC = `RMB_SELFCHECK_TIME_US * (`RMB_CLK_KHZ / 1000),
  parameter int RELOAD_CYC = `RMB_RELOAD_TIME_US * (`RMB_CLK_KHZ / 1000)
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  input wire logic [7:0] host_rx_data,
  input wire logic host_rx_valid,
  output logic host_rx_ready,
  input wire logic uart_out_active,
  output logic [7:0] radio_tx_data,
  output logic radio_tx_valid,
  input wire logic radio_tx_ready,
  output logic radio_tx_last,
  output logic radio_tx_to_all,
  input wire logic [15:0] radio_rx_dest_addr,
  input wire logic radio_rx_valid,
  output logic radio_rx_accept,
  output logic ready_ind,
  output logic [1:0] active_mode,
  output logic mode_working
);

  localparam int LW = $clog2(BUF_DEPTH + 1);
  localparam int TW = $clog2(CHECK_CYC + RELOAD_CYC + 2);
  localparam int HW = $clog2(SETTLE_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // State

  radio_mode_pkg::busy_state_t state_ff;
  radio_mode_pkg::busy_state_t nxt_state;
  radio_mode_pkg::op_mode_t mode_ff;
  radio_mode_pkg::op_mode_t nxt_mode;
  logic [TW-1:0] tmr_ff;
  logic [TW-1:0] nxt_tmr;
  logic [HW-1:0] high_cnt_ff;
  logic ready_ff;
  logic [15:0] own_addr_ff;
  logic [7:0] subpkt_ff;
  logic [7:0] sub_cnt_ff;
  logic [31:0] prdata_ff;
  logic to_all_ff;
  logic rx_accept_ff;

  logic [7:0] fifo_data;
  logic fifo_out_valid;
  logic fifo_in_ready;
  logic [LW-1:0] fifo_level;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and switching

  radio_mode_pkg::op_mode_t pin_mode;
  assign pin_mode = radio_mode_pkg::op_mode_t'({mode_select_high, mode_select_low});
  wire running = (state_ff == radio_mode_pkg::ST_RUN);
  wire radio_on = (mode_ff == radio_mode_pkg::MODE_NORMAL) ||
                  (mode_ff == radio_mode_pkg::MODE_WOR);
  // Pins are looked at only while ready is high or at the end of reload; pending data keeps it low
  wire mode_change = ready_ff && running && (pin_mode != mode_ff);
  wire sleep_exit = mode_change && (mode_ff == radio_mode_pkg::MODE_SLEEP);
  wire fifo_empty = !fifo_out_valid;
  wire idle_next = (nxt_state == radio_mode_pkg::ST_RUN) && fifo_empty &&
                   !uart_out_active;
  wire settled = (high_cnt_ff == HW'(SETTLE_CYC));

  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = tmr_ff;
    nxt_mode = mode_ff;
    case (state_ff)
      radio_mode_pkg::ST_CHECK: begin
        nxt_tmr = tmr_ff + 1'b1;
        if (tmr_ff == TW'(CHECK_CYC - 1)) begin
          nxt_state = radio_mode_pkg::ST_RELOAD;
          nxt_tmr = '0;
        end
      end
      radio_mode_pkg::ST_RELOAD: begin
        nxt_tmr = tmr_ff + 1'b1;
        if (tmr_ff == TW'(RELOAD_CYC - 1)) begin
          nxt_state = radio_mode_pkg::ST_RUN;
          nxt_mode = pin_mode;
        end
      end
      radio_mode_pkg::ST_RUN: begin
        if (mode_change) begin
          nxt_mode = pin_mode;
        end
        if (sleep_exit) begin
          nxt_state = radio_mode_pkg::ST_RELOAD;
          nxt_tmr = '0;
        end
      end
      default: begin
        nxt_state = radio_mode_pkg::ST_CHECK;
        nxt_tmr = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= radio_mode_pkg::ST_CHECK;
      mode_ff <= radio_mode_pkg::MODE_NORMAL;
      tmr_ff <= '0;
      ready_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      tmr_ff <= nxt_tmr;
      ready_ff <= idle_next;
    end
  end

  // Time since the last ready rising edge, saturating at the settle time
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      high_cnt_ff <= '0;
    end else if (clk_en) begin
      if (!ready_ff) high_cnt_ff <= '0;
      else if (!settled) high_cnt_ff <= high_cnt_ff + 1'b1;
    end
  end

  assign ready_ind = ready_ff;
  assign active_mode = mode_ff;
  assign mode_working = ready_ff && settled;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer and radio side

  assign host_rx_ready = fifo_in_ready && running && radio_on;

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH)
  ) u_tx_buf (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .in_data(host_rx_data),
    .in_valid(host_rx_valid && running && radio_on),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_out_valid),
    .out_ready(radio_tx_ready && running && radio_on),
    .level(fifo_level)
  );

  wire tx_fire = radio_tx_valid && radio_tx_ready && clk_en;
  wire sub_end = (sub_cnt_ff == subpkt_ff - 8'h01) || (fifo_level == LW'(1));

  assign radio_tx_data = fifo_data;
  assign radio_tx_valid = fifo_out_valid && running && radio_on;
  assign radio_tx_last = radio_tx_valid && sub_end;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sub_cnt_ff <= 8'h00;
    end else if (tx_fire) begin
      sub_cnt_ff <= sub_end ? 8'h00 : sub_cnt_ff + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Broadcast and monitor addressing

  wire listen_all = (own_addr_ff == `RMB_ADDR_ALL_HI) ||
                    (own_addr_ff == `RMB_ADDR_ALL_LO);
  wire rx_match = radio_rx_valid && (listen_all || radio_rx_dest_addr == own_addr_ff);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      to_all_ff <= 1'b0;
      rx_accept_ff <= 1'b0;
    end else if (clk_en) begin
      to_all_ff <= listen_all;
      rx_accept_ff <= rx_match;
    end
  end

  assign radio_tx_to_all = to_all_ff;
  assign radio_rx_accept = rx_accept_ff;

  ////////////////////////////////////////////////////////////////////////////
  // APB register file

  wire setup = psel && !penable;
  wire access = psel && penable && clk_en;
  wire hit_addr = (paddr == `RMB_OFF_OWN_ADDR);
  wire hit_sub = (paddr == `RMB_OFF_SUBPKT);
  wire hit_stat = (paddr == `RMB_OFF_STATUS);
  wire mapped = hit_addr || hit_sub || hit_stat;
  wire wr_ok = access && pwrite && mapped;
  wire [31:0] status_word = {{(24 - LW){1'b0}}, fifo_level, 2'b00, state_ff,
                             mode_ff, settled, ready_ff};
  wire [31:0] rd_mux = hit_addr ? {16'h0000, own_addr_ff} :
                       hit_sub ? {24'h00_0000, subpkt_ff} :
                       hit_stat ? status_word : 32'h0000_0000;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      own_addr_ff <= `RMB_RST_OWN_ADDR;
      subpkt_ff <= `RMB_RST_SUBPKT;
      prdata_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      if (wr_ok && hit_addr) own_addr_ff <= pwdata[15:0];
      if (wr_ok && hit_sub && pwdata[7:0] != 8'h00) subpkt_ff <= pwdata[7:0];
      if (setup && !pwrite) prdata_ff <= rd_mux;
    end
  end

  assign prdata = prdata_ff;
  assign pready = clk_en;
  assign pslverr = psel && penable && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_low_in_check: assert property (
    !running |-> !ready_ind)
    else $error("ready high during self-check or reload");

  chk_low_on_data: assert property (
    clk_en && fifo_out_valid |=> !ready_ind)
    else $error("ready high while buffer holds data");

  chk_high_when_idle: assert property (
    clk_en && running && !sleep_exit && fifo_empty && !uart_out_active |=> ready_ind)
    else $error("ready low with no busy condition");

  chk_mode_frozen: assert property (
    clk_en && !ready_ind && running |=> $stable(active_mode))
    else $error("mode changed while ready low");

  chk_switch_prompt: assert property (
    clk_en && ready_ind && running && pin_mode != mode_ff
    |=> active_mode == $past(pin_mode))
    else $error("pending mode switch not applied");

  chk_settle_gate: assert property (
    mode_working |-> ready_ind && high_cnt_ff == HW'(SETTLE_CYC))
    else $error("mode working before settle time");

  chk_sleep_reload: assert property (
    clk_en && sleep_exit |=> state_ff == radio_mode_pkg::ST_RELOAD ##1 !ready_ind)
    else $error("leaving sleep did not reload");

  chk_no_overflow: assert property (
    host_rx_ready |-> fifo_level < LW'(BUF_DEPTH))
    else $error("host accepted into full buffer");

  chk_tx_gated: assert property (
    radio_tx_valid |-> running && radio_on && fifo_level != '0)
    else $error("radio transmit outside normal or wake mode");

  chk_broadcast: assert property (
    clk_en && (own_addr_ff == 16'hffff || own_addr_ff == 16'h0000) |=> radio_tx_to_all)
    else $error("broadcast flag missing");

  cov_sleep_exit: cover property (clk_en && sleep_exit);
  cov_settled: cover property (ready_ind ##1 mode_working);
  cov_sub_last: cover property (tx_fire && radio_tx_last && fifo_level > LW'(1));

endmodule

// File: verification/host_burst_model.sv
module host_burst_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic slow,
  input wire logic [7:0] first,
  input wire logic [7:0] count,
  input wire logic host_rx_ready,
  output logic [7:0] host_rx_data,
  output logic host_rx_valid,
  output logic [7:0] sent
);
  timeunit 1ns;
  timeprecision 100ps;
  logic on_ff;
  logic gap_ff;
  logic [7:0] data_ff;
  wire logic take = host_rx_valid && host_rx_ready;
  wire logic done = (sent + 8'h01) == count;
  // Byte held until taken; once the burst ends the line shows the inverse of its last value
  assign host_rx_valid = on_ff && !gap_ff;
  assign host_rx_data = data_ff;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      on_ff <= 1'h0;
      gap_ff <= 1'h0;
      data_ff <= 8'h00;
      sent <= 8'h00;
    end else if (start) begin
      on_ff <= 1'h1;
      data_ff <= first;
      sent <= 8'h00;
    end else if (take) begin
      sent <= sent + 8'h01;
      // Slow host leaves an idle cycle after each byte
      gap_ff <= slow;
      data_ff <= done ? ~data_ff : data_ff + 8'h01;
      on_ff <= !done;
    end else begin
      gap_ff <= 1'h0;
    end
  end
endmodule

// File: verification/test_radio_mode_busy.sv
`include "radio_mode_cfg.svh"

module test_radio_mode_busy;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEPTH = 16;
  localparam int SETTLE = 20;
  localparam int CHECK = 8;
  localparam int RELOAD = 4;
  logic ref_clk = 1'h0, nrst = 1'h0, clk_en = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, err, mode_select_low = 1'h0, mode_select_high = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic host_rx_valid, host_rx_ready, uart_out_active = 1'h0, radio_tx_valid, radio_tx_last;
  logic radio_tx_ready = 1'h0, radio_tx_to_all, radio_rx_valid = 1'h0, radio_rx_accept;
  logic ready_ind, mode_working, start = 1'h0, slow = 1'h0;
  logic [7:0] host_rx_data, radio_tx_data, sent, first = 8'h00, count = 8'h00;
  logic [15:0] radio_rx_dest_addr = 16'h0000;
  logic [1:0] active_mode;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;

  radio_mode_busy #(.BUF_DEPTH(DEPTH), .SETTLE_CYC(SETTLE), .CHECK_CYC(CHECK),
    .RELOAD_CYC(RELOAD)) dut (.ref_clk, .nrst, .clk_en, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .mode_select_low, .mode_select_high, .host_rx_data,
    .host_rx_valid, .host_rx_ready, .uart_out_active, .radio_tx_data, .radio_tx_valid,
    .radio_tx_ready, .radio_tx_last, .radio_tx_to_all, .radio_rx_dest_addr, .radio_rx_valid,
    .radio_rx_accept, .ready_ind, .active_mode, .mode_working);

  host_burst_model host (.ref_clk, .nrst, .start, .slow, .first, .count, .host_rx_ready,
    .host_rx_data, .host_rx_valid, .sent);

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_of_test;
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rx(input logic [15:0] a);
    @(posedge ref_clk);
    radio_rx_dest_addr <= a;
    radio_rx_valid <= 1'h1;
    @(posedge ref_clk);
    radio_rx_valid <= 1'h0;
    #1;
  endtask

  task automatic wait_rdy(input logic v, input int lim);
    for (int i = 0; i < lim && ready_ind !== v; i++) @(posedge ref_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (CHECK) @(posedge ref_clk);
    #1;
    chk("ready in check", ready_ind, 1'h0);
    wait_rdy(1'h1, RELOAD + 8);
    chk("ready after init", ready_ind, 1'h1);
    chk("mode at start", active_mode, radio_mode_pkg::MODE_NORMAL);
    chk("working early", mode_working, 1'h0);
    $display("test reset done");
  endtask

  task automatic t_regs;
    apb(1'h0, `RMB_OFF_STATUS, 32'h0000_0000);
    chk("status", rd, (32'h0000_0001 << `RMB_ST_READY) |
      (32'(radio_mode_pkg::ST_RUN) << `RMB_ST_STATE_LSB));
    apb(1'h0, `RMB_OFF_OWN_ADDR, 32'h0000_0000);
    chk("own addr", rd, 32'(`RMB_RST_OWN_ADDR));
    apb(1'h0, `RMB_OFF_SUBPKT, 32'h0000_0000);
    chk("subpkt", rd, 32'(`RMB_RST_SUBPKT));
    apb(1'h1, 12'h00c, 32'hffff_ffff);
    chk("unmapped err", err, 1'h1);
    apb(1'h1, `RMB_OFF_OWN_ADDR, 32'h0000_ffff);
    chk("mapped ok", err, 1'h0);
    rx(16'h1234);
    chk("to all", radio_tx_to_all, 1'h1);
    chk("monitor", radio_rx_accept, 1'h1);
    apb(1'h1, `RMB_OFF_OWN_ADDR, 32'h0000_0005);
    rx(16'h1234);
    chk("other dest", radio_rx_accept, 1'h0);
    chk("not to all", radio_tx_to_all, 1'h0);
    apb(1'h1, `RMB_OFF_SUBPKT, 32'h0000_0004);
    $display("test regs done");
  endtask

  task automatic t_uart;
    @(posedge ref_clk);
    clk_en <= 1'h0;
    uart_out_active <= 1'h1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("ready frozen", ready_ind, 1'h1);
    chk("pready frozen", pready, 1'h0);
    @(posedge ref_clk);
    clk_en <= 1'h1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("ready uart", ready_ind, 1'h0);
    @(posedge ref_clk);
    uart_out_active <= 1'h0;
    wait_rdy(1'h1, 5);
    chk("ready uart end", ready_ind, 1'h1);
    $display("test uart done");
  endtask

  task automatic t_burst;
    logic [7:0] n;
    @(posedge ref_clk);
    first <= 8'h10;
    count <= 8'(DEPTH);
    slow <= 1'h1;
    start <= 1'h1;
    @(posedge ref_clk);
    start <= 1'h0;
    for (int i = 0; i < 200 && sent !== 8'(DEPTH); i++) @(posedge ref_clk);
    #1;
    chk("burst taken", sent, 8'(DEPTH));
    chk("full refuses", host_rx_ready, 1'h0);
    chk("ready buffered", ready_ind, 1'h0);
    @(posedge ref_clk);
    mode_select_low <= 1'h1;
    repeat (6) @(posedge ref_clk);
    radio_tx_ready <= 1'h1;
    #1;
    chk("mode held busy", active_mode, radio_mode_pkg::MODE_NORMAL);
    n = 8'h00;
    for (int i = 0; i < 100 && n < 8'(DEPTH); i++) begin
      if (radio_tx_valid === 1'h1) begin
        chk("tx data", radio_tx_data, 8'h10 + n);
        chk("tx last", radio_tx_last, n[1:0] == 2'h3);
        n = n + 8'h01;
      end
      @(posedge ref_clk);
      #1;
    end
    chk("drained", n, 8'(DEPTH));
    wait_rdy(1'h1, 5);
    for (int i = 0; i < 3 && active_mode !== radio_mode_pkg::MODE_WOR; i++) @(posedge ref_clk);
    #1;
    chk("pending switch", active_mode, radio_mode_pkg::MODE_WOR);
    chk("not yet working", mode_working, 1'h0);
    repeat (SETTLE + 2) @(posedge ref_clk);
    #1;
    chk("working", mode_working, 1'h1);
    $display("test burst done");
  endtask

  task automatic t_modes;
    @(posedge ref_clk);
    mode_select_high <= 1'h1;
    mode_select_low <= 1'h0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("config", active_mode, radio_mode_pkg::MODE_CONFIG);
    chk("still working", mode_working, 1'h1);
    chk("config refuses", host_rx_ready, 1'h0);
    @(posedge ref_clk);
    mode_select_low <= 1'h1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("sleep", active_mode, radio_mode_pkg::MODE_SLEEP);
    @(posedge ref_clk);
    mode_select_high <= 1'h0;
    mode_select_low <= 1'h0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("reload low", ready_ind, 1'h0);
    wait_rdy(1'h1, RELOAD + 8);
    chk("reload end", ready_ind, 1'h1);
    chk("normal", active_mode, radio_mode_pkg::MODE_NORMAL);
    $display("test modes done");
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'h1;
    // Host stays idle until the burst test, long after the first rise of the ready indicator
    t_reset;
    t_regs;
    t_uart;
    // Mode pins held until the new mode is in effect
    t_burst;
    t_modes;
    end_of_test;
  end
endmodule
